// file: prot_pkg.sv
// Overview of operation
// [RQ1] min oil contact armed only if an input has that function and delay
// [RQ2] engine protections armed only while fuel command on, outside start/stop
// [RQ3] oil contacts trip after continuous delay, only after oil mask expired
// [RQ4] analogue oil protections need a sensor input or nonzero engine type
// [RQ5] minimum oil alarm when pressure at or below threshold for its delay
// [RQ6] low oil contact is a warning, armed and timed like minimum contact
// [RQ7] low oil warning when pressure at or below threshold for its delay
// [RQ8] protections work identically in every operating mode
// [RQ9] emergency stop trips when its input stays active for its delay
// [RQ10] emergency stop ignores other interlocks; designated input defaults to it
// [RQ11] password to register 101 then 99 to 102 within 5 s forces stop
// [RQ12] max power trips when power positive and above threshold for delay
// [RQ13] max power trip gives warning, deactivation or alarm by action setting
// [RQ14] unbalance armed only for two/three phases with generator in tolerance
// [RQ15] voltage unbalance alarm when line voltage difference exceeds threshold
// [RQ16] voltage threshold is a percentage of rated phase voltage
// [RQ17] current unbalance also needs load transferred to generator
// [RQ18] current unbalance alarm when any two currents differ beyond threshold
// [RQ19] current threshold is percent of rated current from voltage and power
// [RQ20] delay timers restart from zero when condition lapses or disarmed
// [RQ21] a zero delay disables the protection entirely
package prot_pkg;
    localparam int num_din  = 4;
    localparam int num_prot = 8;
    localparam int num_trip = 10;

    // modbus holding registers
    localparam logic [15:0] remote_password_entry = 16'h0065;
    localparam logic [15:0] remote_command_entry  = 16'h0066;
    localparam logic [15:0] remote_stop_code      = 16'h0063;

    // digital input function codes
    localparam logic [15:0] min_oil_contact_function = 16'd4221;
    localparam logic [15:0] low_oil_contact_function = 16'd4222;
    localparam logic [15:0] emergency_stop_function  = 16'd4201;
    localparam int          estop_default_input      = 2;

    // timing: delays and mask are counted in ticks
    localparam int clk_freq_mhz   = 250;
    localparam int tick_time_ms   = 100;
    localparam int tick_cycles    = tick_time_ms * clk_freq_mhz * 1000;
    localparam int remote_time_ms = 5000;
    localparam logic [7:0] remote_window_ticks =
        8'(remote_time_ms / tick_time_ms);

    // timer channels
    localparam int ch_min_oil_c = 0;
    localparam int ch_low_oil_c = 1;
    localparam int ch_min_oil_a = 2;
    localparam int ch_low_oil_a = 3;
    localparam int ch_estop     = 4;
    localparam int ch_max_pw    = 5;
    localparam int ch_v_unb     = 6;
    localparam int ch_i_unb     = 7;

    // latched trip bits
    localparam int tr_min_oil_c = 0;
    localparam int tr_low_oil_c = 1;
    localparam int tr_min_oil_a = 2;
    localparam int tr_low_oil_a = 3;
    localparam int tr_estop     = 4;
    localparam int tr_pw_warn   = 5;
    localparam int tr_pw_deact  = 6;
    localparam int tr_pw_alarm  = 7;
    localparam int tr_v_unb     = 8;
    localparam int tr_i_unb     = 9;

    localparam logic [1:0] act_warning = 2'h0;
    localparam logic [1:0] act_deact   = 2'h1;
    localparam logic [1:0] act_alarm   = 2'h2;
    localparam logic [1:0] min_unbal_phases = 2'h2;
    localparam logic [1:0] three_phases     = 2'h3;
    localparam logic [6:0] percent_scale    = 7'd100;
endpackage

// file: prot_timer_if.sv
`timescale 1ns/10ps
interface prot_timer_if;
    logic                                    tick;
    logic [prot_pkg::num_prot-1:0]           arm;
    logic [prot_pkg::num_prot-1:0]           cond;
    logic [prot_pkg::num_prot-1:0][15:0]     delay;
    logic [prot_pkg::num_prot-1:0]           expired;

    modport ctrl (output tick, output arm, output cond, output delay,
                  input expired);
    modport tmr  (input tick, input arm, input cond, input delay,
                  output expired);
endinterface

// file: prot_timer.sv
`timescale 1ns/10ps
module prot_timer (
    input  wire logic  sys_clk,
    input  wire logic  arst_n,
    prot_timer_if.tmr  tif
);
    typedef struct packed {
        logic [prot_pkg::num_prot-1:0][15:0] cnt;
    } tmr_state_s;

    tmr_state_s st_r;
    tmr_state_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        for (int i = 0; i < prot_pkg::num_prot; i++) begin
            if (!tif.arm[i] || !tif.cond[i]) begin
                st_nxt.cnt[i] = 16'h0; // [RQ20]
            end else if (tif.tick && st_r.cnt[i] < tif.delay[i]) begin
                st_nxt.cnt[i] = st_r.cnt[i] + 16'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // trip only after uninterrupted persistence; zero delay never trips
    generate
        for (genvar g = 0; g < prot_pkg::num_prot; g++) begin : g_exp
            assign tif.expired[g] = tif.arm[g] && tif.cond[g] &&
                                    tif.delay[g] != 16'h0 && // [RQ21]
                                    st_r.cnt[g] == tif.delay[g];
        end
    endgenerate

    property p_restart;
        @(posedge sys_clk) disable iff (!arst_n)
        !(tif.arm[0] && tif.cond[0]) |=> st_r.cnt[0] == 16'h0;
    endproperty
    a_restart: assert property (p_restart) // [RQ20]
        else $error("timer not restarted after condition lapse");

    localparam int ch_sel = prot_pkg::ch_max_pw;
    property p_zero_off;
        @(posedge sys_clk) disable iff (!arst_n)
        tif.delay[ch_sel] == 16'h0 |-> !tif.expired[ch_sel];
    endproperty
    a_zero_off: assert property (p_zero_off) // [RQ21]
        else $error("protection expired with zero delay");
endmodule

// file: genset_protection_monitor.sv
`timescale 1ns/10ps
module genset_protection_monitor #(
    parameter int unsigned tick_cycles_p = prot_pkg::tick_cycles
) (
    input  wire logic                                     sys_clk,
    input  wire logic                                     arst_n,
    input  wire logic [prot_pkg::num_din-1:0]             din,
    input  wire logic [prot_pkg::num_din-1:0][15:0]       din_func,
    input  wire logic [prot_pkg::num_din-1:0][15:0]       din_delay,
    input  wire logic                                     fuel_cmd,
    input  wire logic                                     start_stop_phase,
    input  wire logic [15:0]                              oil_mask_time,
    input  wire logic                                     oil_ai_cfg,
    input  wire logic [7:0]                               engine_type,
    input  wire logic [15:0]                              oil_press,
    input  wire logic [15:0]                              min_oil_thr,
    input  wire logic [15:0]                              min_oil_delay,
    input  wire logic [15:0]                              low_oil_thr,
    input  wire logic [15:0]                              low_oil_delay,
    input  wire logic signed [31:0]                       p_total,
    input  wire logic [31:0]                              max_power_thr,
    input  wire logic [15:0]                              max_power_delay,
    input  wire logic [1:0]                               max_power_action,
    input  wire logic [1:0]                               gen_phases,
    input  wire logic                                     gen_in_tol,
    input  wire logic                                     load_on_gen,
    input  wire logic [15:0]                              v_ab,
    input  wire logic [15:0]                              v_bc,
    input  wire logic [15:0]                              v_ca,
    input  wire logic [15:0]                              v_rated,
    input  wire logic [7:0]                               volt_asym_pct,
    input  wire logic [15:0]                              volt_asym_delay,
    input  wire logic [15:0]                              i_a,
    input  wire logic [15:0]                              i_b,
    input  wire logic [15:0]                              i_c,
    input  wire logic [31:0]                              p_nominal,
    input  wire logic [7:0]                               curr_asym_pct,
    input  wire logic [15:0]                              curr_asym_delay,
    input  wire logic [15:0]                              password,
    input  wire logic                                     mb_wr,
    input  wire logic [15:0]                              mb_addr,
    input  wire logic [15:0]                              mb_wdata,
    input  wire logic                                     fault_ack,
    output logic                                          min_oil_contact_alarm,
    output logic                                          low_oil_contact_warning,
    output logic                                          min_oil_alarm,
    output logic                                          low_oil_warning,
    output logic                                          estop_alarm,
    output logic                                          max_power_warning,
    output logic                                          max_power_deact,
    output logic                                          max_power_alarm,
    output logic                                          volt_unbal_alarm,
    output logic                                          curr_unbal_alarm
);
    typedef struct packed {
        logic [31:0]                   pre;
        logic                          tick;
        logic [15:0]                   mask;
        logic [7:0]                    win;
        logic [prot_pkg::num_trip-1:0] trip;
    } mon_state_s;

    mon_state_s st_r;
    mon_state_s st_nxt;

    prot_timer_if tif ();

    prot_timer u_timer (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .tif     (tif)
    );

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [15:0] absdiff(input logic [15:0] a,
                                            input logic [15:0] b);
        absdiff = (a > b) ? a - b : b - a;
    endfunction

    function automatic logic [15:0] max3(input logic [15:0] a,
                                         input logic [15:0] b,
                                         input logic [15:0] c);
        logic [15:0] m;
        m = (a > b) ? a : b;
        max3 = (m > c) ? m : c;
    endfunction

    // an unconfigured designated input acts as emergency stop
    function automatic logic [15:0] eff_func(input int k,
                                             input logic [15:0] f);
        if (k == prot_pkg::estop_default_input && f == 16'h0) begin
            eff_func = prot_pkg::emergency_stop_function; // [RQ10]
        end else begin
            eff_func = f;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // conditions

    logic        engine_run;
    logic        mask_done;
    logic        oil_meas_ok;
    logic        unbal_ok;
    logic [15:0] v_diff;
    logic [15:0] i_diff;
    logic [47:0] v_lhs;
    logic [47:0] v_rhs;
    logic [47:0] i_lhs;
    logic [47:0] i_rhs;
    logic [2:0]  c_act;
    logic [2:0]  c_found;
    logic [2:0][15:0] c_dly;
    logic [15:0] fk;

    // same gating in every operating mode: no mode input exists [RQ8]
    assign engine_run  = fuel_cmd && !start_stop_phase; // [RQ2]
    assign mask_done   = engine_run && st_r.mask >= oil_mask_time; // [RQ3]
    assign oil_meas_ok = oil_ai_cfg || engine_type != 8'h0; // [RQ4]
    assign unbal_ok    = engine_run && gen_in_tol &&
                         gen_phases >= prot_pkg::min_unbal_phases; // [RQ14]

    assign v_diff = (gen_phases == prot_pkg::three_phases) ?
                    max3(absdiff(v_ab, v_bc), absdiff(v_bc, v_ca),
                         absdiff(v_ca, v_ab)) : 16'h0;
    assign i_diff = (gen_phases == prot_pkg::three_phases) ?
                    max3(absdiff(i_a, i_b), absdiff(i_b, i_c),
                         absdiff(i_c, i_a)) : absdiff(i_a, i_b);
    // percentage compare without division [RQ16]
    assign v_lhs = 48'(v_diff) * 48'(prot_pkg::percent_scale);
    assign v_rhs = 48'(volt_asym_pct) * 48'(v_rated);
    // rated current = nominal power / (phases * rated voltage) [RQ19]
    assign i_lhs = 48'(i_diff) * 48'(prot_pkg::percent_scale) *
                   48'(gen_phases) * 48'(v_rated);
    assign i_rhs = 48'(curr_asym_pct) * 48'(p_nominal);

    // contact selection; lowest numbered input wins
    always_comb begin
        c_act   = 3'h0;
        c_found = 3'h0;
        c_dly   = '0;
        fk      = 16'h0;
        for (int k = prot_pkg::num_din - 1; k >= 0; k--) begin
            fk = eff_func(k, din_func[k]);
            if (fk == prot_pkg::min_oil_contact_function) begin // [RQ1]
                c_act[0]   = din[k];
                c_found[0] = 1'b1;
                c_dly[0]   = din_delay[k];
            end
            if (fk == prot_pkg::low_oil_contact_function) begin // [RQ6]
                c_act[1]   = din[k];
                c_found[1] = 1'b1;
                c_dly[1]   = din_delay[k];
            end
            if (fk == prot_pkg::emergency_stop_function) begin // [RQ9]
                c_act[2]   = din[k];
                c_found[2] = 1'b1;
                c_dly[2]   = din_delay[k];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timer channels

    assign tif.tick = st_r.tick;

    assign tif.arm[prot_pkg::ch_min_oil_c]   = c_found[0] && mask_done;
    assign tif.cond[prot_pkg::ch_min_oil_c]  = c_act[0]; // [RQ3]
    assign tif.delay[prot_pkg::ch_min_oil_c] = c_dly[0];

    assign tif.arm[prot_pkg::ch_low_oil_c]   = c_found[1] && mask_done;
    assign tif.cond[prot_pkg::ch_low_oil_c]  = c_act[1]; // [RQ6]
    assign tif.delay[prot_pkg::ch_low_oil_c] = c_dly[1];

    assign tif.arm[prot_pkg::ch_min_oil_a]   = oil_meas_ok && mask_done;
    assign tif.cond[prot_pkg::ch_min_oil_a]  = oil_press <= min_oil_thr;
    assign tif.delay[prot_pkg::ch_min_oil_a] = min_oil_delay; // [RQ5]

    assign tif.arm[prot_pkg::ch_low_oil_a]   = oil_meas_ok && mask_done;
    assign tif.cond[prot_pkg::ch_low_oil_a]  = oil_press <= low_oil_thr;
    assign tif.delay[prot_pkg::ch_low_oil_a] = low_oil_delay; // [RQ7]

    // emergency stop is not gated by engine state or other interlocks
    assign tif.arm[prot_pkg::ch_estop]   = c_found[2]; // [RQ10]
    assign tif.cond[prot_pkg::ch_estop]  = c_act[2]; // [RQ9]
    assign tif.delay[prot_pkg::ch_estop] = c_dly[2];

    assign tif.arm[prot_pkg::ch_max_pw]   = engine_run;
    assign tif.cond[prot_pkg::ch_max_pw]  = p_total > 0 &&
                                            p_total > $signed({1'b0,
                                                max_power_thr[30:0]});
    assign tif.delay[prot_pkg::ch_max_pw] = max_power_delay; // [RQ12]

    assign tif.arm[prot_pkg::ch_v_unb]   = unbal_ok;
    assign tif.cond[prot_pkg::ch_v_unb]  = v_lhs > v_rhs; // [RQ15]
    assign tif.delay[prot_pkg::ch_v_unb] = volt_asym_delay;

    assign tif.arm[prot_pkg::ch_i_unb]   = unbal_ok && load_on_gen; // [RQ17]
    assign tif.cond[prot_pkg::ch_i_unb]  = i_lhs > i_rhs; // [RQ18]
    assign tif.delay[prot_pkg::ch_i_unb] = curr_asym_delay;

    ////////////////////////////////////////////////////////////////////////
    // state update

    logic pw_hit;
    logic cmd_hit;
    logic [prot_pkg::num_trip-1:0] set_v;

    assign pw_hit  = mb_wr && mb_addr == prot_pkg::remote_password_entry &&
                     mb_wdata == password;
    assign cmd_hit = mb_wr && mb_addr == prot_pkg::remote_command_entry &&
                     mb_wdata == prot_pkg::remote_stop_code &&
                     st_r.win != 8'h0; // [RQ11]

    always_comb begin
        st_nxt = st_r;
        set_v  = '0;
        // tick prescaler
        st_nxt.tick = 1'b0;
        if (st_r.pre >= 32'(tick_cycles_p - 1)) begin
            st_nxt.pre  = 32'h0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.pre = st_r.pre + 32'h1;
        end
        // oil mask runs from engine start
        if (!engine_run) begin
            st_nxt.mask = 16'h0; // [RQ3]
        end else if (st_r.tick && st_r.mask != 16'hffff) begin
            st_nxt.mask = st_r.mask + 16'h1;
        end
        // remote stop window
        if (pw_hit) begin
            st_nxt.win = prot_pkg::remote_window_ticks; // [RQ11]
        end else if (cmd_hit) begin
            st_nxt.win = 8'h0;
        end else if (st_r.tick && st_r.win != 8'h0) begin
            st_nxt.win = st_r.win - 8'h1;
        end
        set_v[prot_pkg::tr_min_oil_c] = tif.expired[prot_pkg::ch_min_oil_c];
        set_v[prot_pkg::tr_low_oil_c] = tif.expired[prot_pkg::ch_low_oil_c];
        set_v[prot_pkg::tr_min_oil_a] = tif.expired[prot_pkg::ch_min_oil_a];
        set_v[prot_pkg::tr_low_oil_a] = tif.expired[prot_pkg::ch_low_oil_a];
        set_v[prot_pkg::tr_estop] = tif.expired[prot_pkg::ch_estop] ||
                                    cmd_hit; // [RQ11]
        case (max_power_action) // [RQ13]
            prot_pkg::act_warning:
                set_v[prot_pkg::tr_pw_warn] =
                    tif.expired[prot_pkg::ch_max_pw];
            prot_pkg::act_deact:
                set_v[prot_pkg::tr_pw_deact] =
                    tif.expired[prot_pkg::ch_max_pw];
            prot_pkg::act_alarm:
                set_v[prot_pkg::tr_pw_alarm] =
                    tif.expired[prot_pkg::ch_max_pw];
            default:
                set_v[prot_pkg::tr_pw_alarm] =
                    tif.expired[prot_pkg::ch_max_pw];
        endcase
        set_v[prot_pkg::tr_v_unb] = tif.expired[prot_pkg::ch_v_unb];
        set_v[prot_pkg::tr_i_unb] = tif.expired[prot_pkg::ch_i_unb];
        // set wins over acknowledge
        st_nxt.trip = (st_r.trip & ~{prot_pkg::num_trip{fault_ack}}) | set_v;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign min_oil_contact_alarm   = st_r.trip[prot_pkg::tr_min_oil_c];
    assign low_oil_contact_warning = st_r.trip[prot_pkg::tr_low_oil_c];
    assign min_oil_alarm           = st_r.trip[prot_pkg::tr_min_oil_a];
    assign low_oil_warning         = st_r.trip[prot_pkg::tr_low_oil_a];
    assign estop_alarm             = st_r.trip[prot_pkg::tr_estop];
    assign max_power_warning       = st_r.trip[prot_pkg::tr_pw_warn];
    assign max_power_deact         = st_r.trip[prot_pkg::tr_pw_deact];
    assign max_power_alarm         = st_r.trip[prot_pkg::tr_pw_alarm];
    assign volt_unbal_alarm        = st_r.trip[prot_pkg::tr_v_unb];
    assign curr_unbal_alarm        = st_r.trip[prot_pkg::tr_i_unb];

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_remote_stop;
        @(posedge sys_clk) disable iff (!arst_n)
        cmd_hit |=> estop_alarm;
    endproperty
    a_remote_stop: assert property (p_remote_stop) // [RQ11]
        else $error("remote stop did not raise emergency alarm");

    property p_window_open;
        @(posedge sys_clk) disable iff (!arst_n)
        pw_hit |=> st_r.win == prot_pkg::remote_window_ticks;
    endproperty
    a_window_open: assert property (p_window_open) // [RQ11]
        else $error("password did not open the command window");

    property p_mask_restart;
        @(posedge sys_clk) disable iff (!arst_n)
        !engine_run |=> st_r.mask == 16'h0 && !mask_done ||
                        oil_mask_time == 16'h0;
    endproperty
    a_mask_restart: assert property (p_mask_restart) // [RQ2]
        else $error("oil mask kept counting while engine stopped");

    property p_oil_c_masked;
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(min_oil_contact_alarm) |-> $past(mask_done) ||
                                          $past(fault_ack);
    endproperty
    a_oil_c_masked: assert property (p_oil_c_masked) // [RQ3]
        else $error("oil contact tripped during oil mask");

    property p_low_oil_a;
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(low_oil_warning) |-> $past(oil_press <= low_oil_thr) &&
                                   $past(oil_meas_ok);
    endproperty
    a_low_oil_a: assert property (p_low_oil_a) // [RQ7]
        else $error("low oil warning without low pressure");

    property p_pw_action;
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(max_power_warning) |->
            $past(max_power_action) == prot_pkg::act_warning;
    endproperty
    a_pw_action: assert property (p_pw_action) // [RQ13]
        else $error("max power warning with other action");

    property p_v_unb_phases;
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(volt_unbal_alarm) |->
            $past(gen_phases) >= prot_pkg::min_unbal_phases &&
            $past(gen_in_tol);
    endproperty
    a_v_unb_phases: assert property (p_v_unb_phases) // [RQ14]
        else $error("voltage unbalance while not armed");

    property p_i_unb_load;
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(curr_unbal_alarm) |-> $past(load_on_gen);
    endproperty
    a_i_unb_load: assert property (p_i_unb_load) // [RQ17]
        else $error("current unbalance without load on generator");

    property p_pw_positive;
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(max_power_alarm) |-> $past(p_total) > 0;
    endproperty
    a_pw_positive: assert property (p_pw_positive) // [RQ12]
        else $error("max power trip with non-positive power");
endmodule

// file: field_model.sv
`timescale 1ns/10ps
module field_model (
    input  wire logic        sys_clk,
    output logic             mb_wr,
    output logic [15:0]      mb_addr,
    output logic [15:0]      mb_wdata
);
    initial begin
        mb_wr = 1'b0;
        mb_addr = 16'h0000;
        mb_wdata = 16'h0000;
    end
    // one-cycle write strobe, bus scrambled once released
    task automatic mb_write(logic [15:0] a, logic [15:0] d);
        @(posedge sys_clk);
        mb_wr <= 1'b1;
        mb_addr <= a;
        mb_wdata <= d;
        @(posedge sys_clk);
        mb_wr <= 1'b0;
        mb_addr <= ~a;
        mb_wdata <= ~d;
    endtask
endmodule

// file: genset_protection_monitor_tb.sv
`timescale 1ns/10ps
module genset_protection_monitor_tb;
    logic sys_clk = 1'b0, arst_n = 1'b0, fuel_cmd = 1'b0, fault_ack = 1'b0;
    logic start_stop_phase = 1'b0, oil_ai_cfg = 1'b1, gen_in_tol = 1'b0;
    logic load_on_gen = 1'b0, mb_wr, min_oil_contact_alarm, min_oil_alarm;
    logic low_oil_contact_warning, low_oil_warning, estop_alarm;
    logic max_power_warning, max_power_deact, max_power_alarm;
    logic volt_unbal_alarm, curr_unbal_alarm;
    logic [3:0] din = 4'h0;
    logic [3:0][15:0] din_func = 64'h0, din_delay = 64'h0002_0001_0001;
    logic [15:0] oil_mask_time = 16'h2, oil_press = 16'h5, min_oil_thr = 16'h5;
    logic [15:0] min_oil_delay = 16'h2, low_oil_thr = 16'h5;
    logic [15:0] password = 16'h1234;
    logic [15:0] low_oil_delay = 16'h0, max_power_delay = 16'h0, v_ab = 16'h0;
    logic [15:0] v_bc = 16'h0, v_ca = 16'h0, v_rated = 16'h0, i_a = 16'h0;
    logic [15:0] i_b = 16'h0, i_c = 16'h0, mb_addr, mb_wdata;
    logic [15:0] volt_asym_delay = 16'h0, curr_asym_delay = 16'h0;
    logic [7:0] engine_type = 8'h0, volt_asym_pct = 8'h0, curr_asym_pct = 8'h0;
    logic signed [31:0] p_total = 32'h0;
    logic [31:0] max_power_thr = 32'h0, p_nominal = 32'h0;
    logic [1:0] max_power_action = 2'h0, gen_phases = 2'h3;
    logic [9:0] outs;
    int n_errors = 0, n_compared = 0, cyc = 0;
    assign outs = {curr_unbal_alarm, volt_unbal_alarm, max_power_alarm,
        max_power_deact, max_power_warning, estop_alarm, low_oil_warning,
        min_oil_alarm, low_oil_contact_warning, min_oil_contact_alarm};
    field_model fm (.sys_clk, .mb_wr, .mb_addr, .mb_wdata);
    genset_protection_monitor #(.tick_cycles_p(4)) dut (.sys_clk, .arst_n,
        .din, .din_func, .din_delay, .fuel_cmd, .start_stop_phase,
        .oil_mask_time, .oil_ai_cfg, .engine_type, .oil_press, .min_oil_thr,
        .min_oil_delay, .low_oil_thr, .low_oil_delay, .p_total, .max_power_thr,
        .max_power_delay, .max_power_action, .gen_phases, .gen_in_tol,
        .load_on_gen, .v_ab, .v_bc, .v_ca, .v_rated, .volt_asym_pct,
        .volt_asym_delay, .i_a, .i_b, .i_c, .p_nominal, .curr_asym_pct,
        .curr_asym_delay, .password, .mb_wr, .mb_addr, .mb_wdata, .fault_ack,
        .min_oil_contact_alarm, .low_oil_contact_warning, .min_oil_alarm,
        .low_oil_warning, .estop_alarm, .max_power_warning, .max_power_deact,
        .max_power_alarm, .volt_unbal_alarm, .curr_unbal_alarm);
    ////////////////////////////////////////////////////////////////////
    task automatic check(string nm, logic got, logic exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %b, seen %b", nm, exp, got);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic await(string nm, int b, int n);
        repeat (n) if (outs[b] !== 1'b1) step(1);
        check(nm, outs[b], 1'b1);
    endtask
    task automatic clear();
        @(posedge sys_clk);
        din <= 4'h0;
        fault_ack <= 1'b1;
        @(posedge sys_clk);
        fault_ack <= 1'b0;
    endtask
    task automatic t_field();
        @(posedge sys_clk);
        din_func[1:0] <= {prot_pkg::min_oil_contact_function,
                          prot_pkg::low_oil_contact_function};
        din[1:0] <= 2'h3;
        max_power_action <= prot_pkg::act_alarm;
        {gen_in_tol, load_on_gen} <= 2'h3;
        {v_ab, v_bc, v_ca, v_rated} <= 64'h0064_0064_005a_0064;
        {i_a, i_b, i_c} <= 48'h000a_000a_0000;
        p_nominal <= 32'hbb8;
        {volt_asym_pct, curr_asym_pct} <= 16'h0532;
        {volt_asym_delay, curr_asym_delay} <= 32'h0001_0001;
        await("min oil contact", prot_pkg::tr_min_oil_c, 20);
        await("low oil contact", prot_pkg::tr_low_oil_c, 20);
        await("power alarm", prot_pkg::tr_pw_alarm, 20);
        await("volt unbalance", prot_pkg::tr_v_unb, 20);
        await("curr unbalance", prot_pkg::tr_i_unb, 20);
    endtask
    task automatic tally_and_finish();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        din[2] <= 1'b1;
        step(3);
        check("estop early", estop_alarm, 1'b0);
        await("estop", prot_pkg::tr_estop, 20);
        clear();
        fm.mb_write(prot_pkg::remote_password_entry, password ^ 16'h1);
        fm.mb_write(prot_pkg::remote_command_entry, prot_pkg::remote_stop_code);
        step(3);
        check("remote refused", estop_alarm, 1'b0);
        check("oil fuel off", min_oil_alarm, 1'b0);
        fm.mb_write(prot_pkg::remote_password_entry, password);
        fm.mb_write(prot_pkg::remote_command_entry, prot_pkg::remote_stop_code);
        await("remote", prot_pkg::tr_estop, 3);
        clear();
        fuel_cmd <= 1'b1;
        step(6);
        check("oil masked", min_oil_alarm, 1'b0);
        await("min oil", prot_pkg::tr_min_oil_a, 30);
        check("low oil off", low_oil_warning, 1'b0);
        @(posedge sys_clk);
        p_total <= 32'h3e8;
        max_power_thr <= 32'h1f4;
        max_power_delay <= 16'h1;
        max_power_action <= prot_pkg::act_deact;
        await("power deact", prot_pkg::tr_pw_deact, 20);
        check("power warn", max_power_warning, 1'b0);
        t_field();
        tally_and_finish();
    end
endmodule
